//--- rtl/bpr_pkg.sv
// Purpose: Shared constants and carriers for the breakpoint status unit
// Assumes: One retired-instruction event per core_clk cycle at most
// Notes:   Four address slots, 32-bit linear addresses
package bpr_pkg;

    localparam int          BPR_SLOTS      = 4;
    localparam int          BPR_ADDR_W     = 32;
    localparam int          BPR_PAGE_W     = 12;
    localparam logic [12:0] BPR_PAGE_BYTES = 13'h1000;

    // Access-type field encodings
    localparam logic [1:0]  BPR_TYPE_EXEC  = 2'h0;
    localparam logic [1:0]  BPR_TYPE_WRITE = 2'h1;
    localparam logic [1:0]  BPR_TYPE_IO    = 2'h2;
    localparam logic [1:0]  BPR_TYPE_RW    = 2'h3;

    // Reset values
    localparam logic [3:0]  BPR_MATCH_RST  = 4'h0;
    localparam logic        BPR_FLAG_RST   = 1'b0;
    localparam logic [31:0] BPR_ADDR_RST   = 32'h0000_0000;

    typedef struct packed {
        logic [3:0]      task_local_enables;
        logic [3:0]      global_enables;
        logic [3:0][1:0] access_type_field;
        logic            general_detect_arm;
    } bpr_ctrl_t;

    typedef struct packed {
        logic       protection_fault_flag;
        logic [3:0] slot_match_flags;
    } bpr_status_t;

    // One retired instruction as seen by the debug unit
    typedef struct packed {
        logic        valid;
        logic [31:0] fetch_addr;
        logic        fetch_page_fault;
        logic        stack_segment_load;
        logic        soft_interrupt;
        logic        debug_reg_access;
        logic        data_valid;
        logic        data_write;
        logic [31:0] data_addr;
        logic [3:0]  data_len;
        logic        ad_bit_update;
    } bpr_insn_t;

endpackage

//--- rtl/bpr_slot_match.sv
// Purpose: Address and type compare for one breakpoint slot
// Assumes: Exact address compare, length bits not modelled
// Notes:   Pure combinational, instantiated once per slot
`timescale 1ns/10ps
module bpr_slot_match
    import bpr_pkg::*;
(
    input  wire logic [31:0] slot_addr,
    input  wire logic [1:0]  slot_type,
    input  wire logic        local_en,
    input  wire logic        global_en,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        data_valid,
    input  wire logic        data_write,
    input  wire logic [31:0] data_addr,
    output logic             slot_enabled,
    output logic             code_hit,
    output logic             data_hit
);
    wire data_type_ok = (slot_type == BPR_TYPE_RW) || ((slot_type == BPR_TYPE_WRITE) && data_write);

    assign slot_enabled = local_en | global_en;
    assign code_hit     = (slot_type == BPR_TYPE_EXEC) && (slot_addr == fetch_addr);
    assign data_hit     = data_valid && data_type_ok && (slot_addr == data_addr);
endmodule

//--- rtl/bpr_unit.sv
// Purpose: Breakpoint matching and sticky debug status reporting
// Assumes: insn carries one retired instruction per valid cycle
// Notes:   All outputs registered; report pulses are one cycle
`timescale 1ns/10ps
module bpr_unit
    import bpr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ctrl_wr,
    input  wire bpr_ctrl_t   ctrl_wdata,
    input  wire logic [3:0]  slot_addr_wr,
    input  wire logic [31:0] slot_addr_wdata,
    input  wire bpr_status_t status_clr,
    input  wire bpr_insn_t   insn,
    input  wire logic        management_interrupt,
    output bpr_ctrl_t        debug_control_reg,
    output bpr_status_t      debug_status_reg,
    output logic             instr_bp_fault,
    output logic             data_bp_report,
    output logic             repeat_report,
    output logic             gd_fault,
    output logic             mgmt_service
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0]      breakpoint_address_slots [BPR_SLOTS];
    logic [3:0]       pend_mask;
    logic             pend_valid;
    logic [3:0]       slot_en;
    logic [3:0]       code_hit;
    logic [3:0]       data_hit;

    genvar g;
    generate
        for (g = 0; g < BPR_SLOTS; g++) begin : g_slot
            bpr_slot_match u_match (
                .slot_addr    (breakpoint_address_slots[g]),
                .slot_type    (debug_control_reg.access_type_field[g]),
                .local_en     (debug_control_reg.task_local_enables[g]),
                .global_en    (debug_control_reg.global_enables[g]),
                .fetch_addr   (insn.fetch_addr),
                .data_valid   (insn.data_valid),
                .data_write   (insn.data_write),
                .data_addr    (insn.data_addr),
                .slot_enabled (slot_en[g]),
                .code_hit     (code_hit[g]),
                .data_hit     (data_hit[g])
            );
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    breakpoint_address_slots[g] <= BPR_ADDR_RST;
                end else if (slot_addr_wr[g]) begin
                    breakpoint_address_slots[g] <= slot_addr_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Match decoding
    wire        any_en       = |slot_en;
    wire [3:0]  flag_gate    = slot_en | {4{any_en}};
    wire [3:0]  code_flags   = insn.valid ? (code_hit & flag_gate) : 4'h0;
    wire [3:0]  data_flags   = insn.valid ? (data_hit & flag_gate) : 4'h0;
    wire        code_on      = |(code_hit & slot_en);
    wire        code_pf      = insn.fetch_page_fault & any_en & (|(code_hit & ~slot_en));
    wire        code_fault   = insn.valid & (code_on | code_pf);
    wire        data_fire    = insn.valid & (|(data_hit & slot_en));
    wire        data_now     = data_fire & ~insn.stack_segment_load;
    wire        ss_capture   = data_fire & insn.stack_segment_load;

    // Follow-on instruction after a stack-segment load
    wire        follow       = insn.valid & pend_valid;
    wire [12:0] store_end    = {1'b0, insn.data_addr[BPR_PAGE_W-1:0]} + {9'h000, insn.data_len};
    wire        page_cross   = store_end > BPR_PAGE_BYTES;
    wire        store_drop   = insn.data_valid & insn.data_write & (page_cross | insn.ad_bit_update);
    wire        gd_hit       = insn.valid & insn.debug_reg_access & debug_control_reg.general_detect_arm;
    wire        soft_clear   = follow & insn.soft_interrupt;
    wire        pend_report  = follow & ~store_drop & ~insn.soft_interrupt & ~gd_hit;
    wire        data_any     = data_now | pend_report;
    wire        mgmt_win     = management_interrupt & data_any;
    wire        data_out     = data_any & ~management_interrupt;
    wire [3:0]  pend_flags   = (pend_report & ~management_interrupt) ? pend_mask : 4'h0;
    wire [3:0]  now_flags    = management_interrupt ? 4'h0 : data_flags;
    wire [3:0]  gd_mask      = (follow & gd_hit) ? 4'h0 : 4'hF;
    wire [3:0]  set_mask     = (code_flags | (ss_capture ? 4'h0 : now_flags) | pend_flags) & gd_mask;
    wire [3:0]  keep_mask    = soft_clear ? 4'h0 : ~status_clr.slot_match_flags;
    wire [3:0]  next_match   = (debug_status_reg.slot_match_flags & keep_mask) | set_mask;
    wire        next_prot    = (debug_status_reg.protection_fault_flag & ~status_clr.protection_fault_flag)
                               | gd_hit;
    wire        dbl_report   = insn.valid & insn.debug_reg_access & (code_fault | data_out);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (rst) begin
            debug_control_reg <= '0;
        end else if (ctrl_wr) begin
            debug_control_reg <= ctrl_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_valid <= BPR_FLAG_RST;
            pend_mask  <= BPR_MATCH_RST;
        end else if (insn.valid) begin
            pend_valid <= ss_capture;
            pend_mask  <= data_flags;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            debug_status_reg <= '0;
            instr_bp_fault   <= BPR_FLAG_RST;
            data_bp_report   <= BPR_FLAG_RST;
            repeat_report    <= BPR_FLAG_RST;
            gd_fault         <= BPR_FLAG_RST;
            mgmt_service     <= BPR_FLAG_RST;
        end else begin
            debug_status_reg.slot_match_flags      <= next_match;
            debug_status_reg.protection_fault_flag <= next_prot;
            instr_bp_fault <= code_fault;
            data_bp_report <= data_out;
            repeat_report  <= dbl_report;
            gd_fault       <= gd_hit;
            mgmt_service   <= mgmt_win;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    enabled_code_fault_a: assert property (insn.valid && |(code_hit & slot_en) |=> instr_bp_fault)
        else $error("enabled code match gave no fault");
    no_enable_no_fault_a: assert property (insn.valid && !any_en |=> !instr_bp_fault)
        else $error("fault with all slots disabled");
    disabled_pf_fault_a: assert property (insn.valid && any_en && insn.fetch_page_fault
        && |(code_hit & ~slot_en) |=> instr_bp_fault)
        else $error("disabled slot page-fault fetch missed fault");
    gd_only_prot_a: assert property (follow && gd_hit && code_flags == 4'h0 && status_clr == '0
        |=> debug_status_reg.protection_fault_flag
            && debug_status_reg.slot_match_flags == $past(debug_status_reg.slot_match_flags))
        else $error("slot flags set on general detect");
    page_cross_drop_a: assert property (follow && store_drop && !data_now |=> !data_bp_report)
        else $error("pending breakpoint survived bad store");
    soft_int_clear_a: assert property (soft_clear && set_mask == 4'h0
        |=> debug_status_reg.slot_match_flags == 4'h0)
        else $error("soft interrupt left slot flags");
    mgmt_first_a: assert property (management_interrupt && data_now |=> mgmt_service && !data_bp_report)
        else $error("breakpoint not dropped for management interrupt");
    double_report_a: assert property (insn.valid && insn.debug_reg_access && code_fault
        |=> instr_bp_fault && repeat_report)
        else $error("debug register hit reported once");
    disabled_flag_a: assert property (insn.valid && !any_en && !pend_valid && status_clr == '0
        |=> debug_status_reg.slot_match_flags == $past(debug_status_reg.slot_match_flags))
        else $error("flag set with no slot enabled");
    sticky_flags_a: assert property (status_clr == '0 && !soft_clear
        |=> ($past(debug_status_reg.slot_match_flags) & ~debug_status_reg.slot_match_flags) == 4'h0)
        else $error("sticky flag dropped without clear");

    pf_fault_c: cover property (insn.valid && code_pf);
    gd_follow_c: cover property (follow && gd_hit);
    mgmt_drop_c: cover property (mgmt_win);
    // Reporting paths of enabled and pending data matches
    data_report_a: assert property (data_now && !management_interrupt |=> data_bp_report)
        else $error("enabled data match not reported");
    no_enable_data_a: assert property (insn.valid && !any_en && !pend_valid
        |=> !data_bp_report)
        else $error("data report with all slots disabled");
    ss_held_a: assert property (insn.valid && insn.stack_segment_load && !follow
        |=> !data_bp_report)
        else $error("stack load breakpoint reported at once");
    pend_report_a: assert property (pend_report && !management_interrupt
        |=> data_bp_report)
        else $error("kept pending breakpoint not reported");

    // Clearing, general detect and management interrupt paths
    soft_no_report_a: assert property (soft_clear && !data_now
        |=> !data_bp_report)
        else $error("pending breakpoint reported after soft interrupt");
    gd_prot_set_a: assert property (gd_hit
        |=> gd_fault && debug_status_reg.protection_fault_flag)
        else $error("general detect not flagged");
    mgmt_no_flags_a: assert property (management_interrupt && data_now && !follow && code_flags == 4'h0
        && status_clr == '0 |=> debug_status_reg.slot_match_flags == $past(debug_status_reg.slot_match_flags))
        else $error("dropped breakpoint set slot flags");
    match_clear_a: assert property (status_clr.slot_match_flags == 4'hF && set_mask == 4'h0
        |=> debug_status_reg.slot_match_flags == 4'h0)
        else $error("slot flag clear not taken");
    prot_clear_a: assert property (status_clr.protection_fault_flag && !gd_hit
        |=> !debug_status_reg.protection_fault_flag)
        else $error("protection flag clear not taken");

    ss_report_c: cover property (ss_capture ##1 !insn.valid ##1 pend_report ##1 data_bp_report);
    dbl_report_c: cover property (dbl_report);
endmodule

//--- verification/bpr_unit_test.sv
// Purpose: Self-checking bench for the breakpoint status unit
// Assumes: Ports driven on falling edge, answers one cycle after take
// Notes:   Observed word is {pulses[4:0], status[4:0]}
`timescale 1ns/10ps
module bpr_unit_test
    import bpr_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        ctrl_wr  = 1'b0;
    bpr_ctrl_t   ctrl_wdata = '0;
    logic [3:0]  slot_addr_wr = 4'h0;
    logic [31:0] slot_addr_wdata = 32'h0;
    bpr_status_t status_clr = '0;
    bpr_insn_t   insn = '0;
    logic        management_interrupt = 1'b0;
    bpr_ctrl_t   debug_control_reg;
    bpr_status_t debug_status_reg;
    logic        instr_bp_fault, data_bp_report, repeat_report, gd_fault, mgmt_service;
    wire  [9:0]  obs = {instr_bp_fault, data_bp_report, repeat_report, gd_fault, mgmt_service, debug_status_reg};
    int          error_cnt   = 0;
    int          comparisons = 0;

    always #50 core_clk = ~core_clk;

    bpr_unit bpr_unit_inst (.core_clk(core_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .slot_addr_wr(slot_addr_wr), .slot_addr_wdata(slot_addr_wdata), .status_clr(status_clr), .insn(insn),
        .management_interrupt(management_interrupt), .debug_control_reg(debug_control_reg),
        .debug_status_reg(debug_status_reg), .instr_bp_fault(instr_bp_fault), .data_bp_report(data_bp_report),
        .repeat_report(repeat_report), .gd_fault(gd_fault), .mgmt_service(mgmt_service));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Control write; slot types: 3 exec, 2 exec, 1 write, 0 read/write
    task automatic setc(input logic gd, input logic [3:0] le, input logic [3:0] ge);
        @(negedge core_clk);
        ctrl_wr    = 1'b1;
        ctrl_wdata = '{le, ge, {BPR_TYPE_EXEC, BPR_TYPE_EXEC, BPR_TYPE_WRITE, BPR_TYPE_RW}, gd};
        @(negedge core_clk);
        ctrl_wr    = 1'b0;
        chk(32'(debug_control_reg), 32'(ctrl_wdata));
    endtask

    task automatic wa(input logic [1:0] i, input logic [31:0] a);
        @(negedge core_clk);
        slot_addr_wr    = 4'h1 << i;
        slot_addr_wdata = a;
        @(negedge core_clk);
        slot_addr_wr    = 4'h0;
    endtask

    task automatic clr();
        @(negedge core_clk);
        status_clr = '1;
        @(negedge core_clk);
        status_clr = '0;
        chk(32'(obs), 32'h0);
    endtask

    // f = {page fault, stack load, soft int, debug reg access, data valid, write, A/D update}
    task automatic step(input logic [31:0] fa, input logic [31:0] da, input logic [3:0] ln,
                        input logic [6:0] f, input logic mi, input logic [9:0] exp);
        @(negedge core_clk);
        insn = '{1'b1, fa, f[6], f[5], f[4], f[3], f[2], f[1], da, ln, f[0]};
        management_interrupt = mi;
        @(negedge core_clk);
        insn = '0;
        management_interrupt = 1'b0;
        chk(32'(obs), 32'(exp));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        chk(32'(obs), 32'h0);
        chk(32'(debug_control_reg), 32'h0);
        wa(2'h0, 32'h0000_2000);
        wa(2'h1, 32'h0000_3FFE);
        wa(2'h2, 32'h0000_5000);
        wa(2'h3, 32'h0000_6000);
        setc(1'b0, 4'h1, 4'hA);
        step(32'h100, 32'h0000_2000, 4'h1, 7'h04, 1'b0, 10'h101);
        repeat (3) @(negedge core_clk);
        chk(32'(obs), 32'h001);
        clr();
        step(32'h100, 32'h0000_3FFE, 4'h2, 7'h06, 1'b0, 10'h102);
        clr();
        step(32'h0000_5000, 32'h0, 4'h1, 7'h00, 1'b0, 10'h004);
        step(32'h0000_5000, 32'h0, 4'h1, 7'h40, 1'b0, 10'h204);
        clr();
        step(32'h0000_6000, 32'h0, 4'h1, 7'h00, 1'b0, 10'h208);
        clr();
        step(32'h100, 32'h0000_3FFE, 4'h2, 7'h26, 1'b0, 10'h000);
        step(32'h100, 32'h0000_0FFE, 4'h4, 7'h06, 1'b0, 10'h000);
        step(32'h100, 32'h0000_3FFE, 4'h2, 7'h26, 1'b0, 10'h000);
        step(32'h100, 32'h0000_0500, 4'h4, 7'h07, 1'b0, 10'h000);
        step(32'h100, 32'h0000_3FFE, 4'h2, 7'h26, 1'b0, 10'h000);
        step(32'h100, 32'h0000_0FFC, 4'h4, 7'h06, 1'b0, 10'h102);
        clr();
        step(32'h100, 32'h0000_2000, 4'h1, 7'h04, 1'b0, 10'h101);
        step(32'h100, 32'h0000_3FFE, 4'h2, 7'h26, 1'b0, 10'h001);
        step(32'h100, 32'h0, 4'h1, 7'h10, 1'b0, 10'h000);
        setc(1'b1, 4'h1, 4'hA);
        step(32'h100, 32'h0000_3FFE, 4'h2, 7'h26, 1'b0, 10'h000);
        step(32'h100, 32'h0, 4'h1, 7'h08, 1'b0, 10'h050);
        clr();
        setc(1'b0, 4'h1, 4'hA);
        step(32'h100, 32'h0000_2000, 4'h1, 7'h04, 1'b1, 10'h020);
        step(32'h100, 32'h0000_2000, 4'h1, 7'h0C, 1'b0, 10'h181);
        clr();
        setc(1'b0, 4'h0, 4'h0);
        step(32'h0000_5000, 32'h0, 4'h1, 7'h40, 1'b0, 10'h000);
        step(32'h0000_6000, 32'h0000_2000, 4'h1, 7'h44, 1'b0, 10'h000);
        give_verdict();
    end
endmodule
